// ===== core/input_mux_ctrl.sv
// Two-port input selector control and charging mode control.
// Assumes analog comparators and straps arrive asynchronously and that
// the watchdog pulse comes from logic on mclk.
`timescale 1ns/1ps
`include "input_mux_map.svh"
module input_mux_ctrl (
   input wire logic mclk, // 40 MHz clock
   input wire logic reset_n, // Sync reset, active low
   input wire logic [7:0] addr, // Register byte offset
   input wire logic [7:0] wdata, // Write data
   input wire logic wr_en, // Write strobe
   input wire logic rd_en, // Read strobe
   output logic [7:0] rdata, // Read data, cycle after strobe
   input wire logic port1_input, // Port 1 above present level
   input wire logic port1_ovp, // Port 1 overvoltage
   input wire logic port2_input, // Port 2 above present level
   input wire logic port2_ovp, // Port 2 overvoltage
   input wire logic bus_rail, // Bus rail above present level
   input wire logic bus_overvoltage_fault, // Bus overvoltage
   input wire logic conv_fault, // Other converter fault
   input wire logic port1_fet_detect, // Port 1 FETs fitted strap
   input wire logic port2_fet_detect, // Port 2 FETs fitted strap
   input wire logic watchdog_expired, // Watchdog pulse, same clock
   output logic port1_gate_drive, // Port 1 gate driver on
   output logic port2_gate_drive, // Port 2 gate driver on
   output logic bypass_fets_on, // Blocking and high-side FETs on
   output logic switcher_run, // Switched-capacitor running
   output logic bus_pulldown_on, // Bus pulldown on
   output logic port1_pulldown_on, // Port 1 pulldown on
   output logic port2_pulldown_on, // Port 2 pulldown on
   output logic irq // Interrupt, high level
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   input_mux_pkg::sense_s sense_raw; // Pins as they arrive
   input_mux_pkg::sense_s sense_meta; // First sync stage
   input_mux_pkg::sense_s sense_sync; // Second sync stage
   input_mux_pkg::ctrl_s ctrl_reg, ctrl_next; // Control word
   input_mux_pkg::drive_s drive_reg, drive_next; // Drive states
   input_mux_pkg::evt_s stat_reg, stat_next; // Sticky events
   input_mux_pkg::evt_s en_reg, en_next; // Interrupt enables
   input_mux_pkg::evt_s evt; // Events this cycle
   logic [1:0] pop_reg, pop_next; // Populated ports
   logic [1:0] popcnt_reg, popcnt_next; // Strap settle count
   logic gate1_reg, gate1_next; // Port 1 driver
   logic gate2_reg, gate2_next; // Port 2 driver
   logic bypass_reg, bypass_next; // Bypass FETs
   logic switch_reg, switch_next; // Switcher run
   logic irq_reg, irq_next; // Interrupt line
   logic [7:0] rdata_reg, rdata_next; // Read data
   logic wr_ctrl, wr_drive, wr_clr, wr_en_reg; // Write decodes
   logic ok1, ok2; // Port may be driven
   logic rev_fault; // Overvoltage seen in reverse
   logic any_fault; // Any converter-stopping fault

   // Address match, used by every write decode
   function automatic logic hit(input logic [7:0] a,
                                input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   assign sense_raw = '{port2_fet_detect: port2_fet_detect,
                        port1_fet_detect: port1_fet_detect,
                        conv_fault: conv_fault,
                        bus_overvoltage_fault: bus_overvoltage_fault,
                        bus_rail_present: bus_rail,
                        port2_ovp: port2_ovp,
                        port2_present: port2_input,
                        port1_ovp: port1_ovp,
                        port1_present: port1_input};

   // Two stages; only the second stage is read by logic
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         sense_meta <= input_mux_pkg::sense_s'(`SENSE_RST);
         sense_sync <= input_mux_pkg::sense_s'(`SENSE_RST);
      end else begin
         sense_meta <= sense_raw;
         sense_sync <= sense_meta;
      end
   end

   // ----------------------------------------
   // Population straps
   // ----------------------------------------
   // Straps are caught after release, once the syncs have settled
   always_comb begin
      popcnt_next = popcnt_reg;
      pop_next = pop_reg;
      if (popcnt_reg != `POP_WAIT) begin
         popcnt_next = 2'(popcnt_reg + 2'h1);
         pop_next = {sense_sync.port2_fet_detect,
                     sense_sync.port1_fet_detect};
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         popcnt_reg <= 2'h0;
         pop_reg <= 2'h0;
      end else begin
         popcnt_reg <= popcnt_next;
         pop_reg <= pop_next;
      end
   end

   // ----------------------------------------
   // Control, drive state and events
   // ----------------------------------------
   assign wr_ctrl = wr_en && hit(addr, `OFS_CTRL);
   assign wr_drive = wr_en && hit(addr, `OFS_DRIVE);
   assign wr_clr = wr_en && hit(addr, `OFS_IRQ_CLR);
   assign wr_en_reg = wr_en && hit(addr, `OFS_IRQ_EN);
   assign rev_fault = sense_sync.bus_overvoltage_fault
                      || sense_sync.port1_ovp || sense_sync.port2_ovp;
   assign any_fault = rev_fault || sense_sync.conv_fault;

   always_comb begin
      ctrl_next = ctrl_reg;
      drive_next = drive_reg;
      evt = input_mux_pkg::evt_s'(`EVT_RST);
      ok1 = 1'b0;
      ok2 = 1'b0;
      // Host writes land first, device effects override them
      if (wr_ctrl) begin
         ctrl_next = input_mux_pkg::ctrl_s'(wdata);
         if (ctrl_next.reverse_output_enable
             && !ctrl_reg.reverse_output_enable) begin
            ctrl_next.all_drivers_disable = 1'b1;
            evt.reverse_entry = 1'b1;
         end
      end
      if (wr_drive) begin
         drive_next.port1_drive_state = wdata[0];
         drive_next.port2_drive_state = wdata[1] && !wdata[0];
      end
      if (watchdog_expired && ctrl_next.reverse_output_enable) begin
         ctrl_next.reverse_output_enable = 1'b0;
         evt.wdog_exit = 1'b1;
      end
      if (any_fault && ctrl_next.charge_enable) begin
         ctrl_next.charge_enable = 1'b0;
         evt.charge_stop = 1'b1;
      end
      if (ctrl_next.reverse_output_enable) begin
         // Reverse mode: host picks the port, device only drops it
         ok1 = !rev_fault;
         ok2 = !rev_fault;
         if (rev_fault && (drive_next != '0)) begin
            drive_next = '0;
            evt.drive_fault = 1'b1;
         end
      end else begin
         ok1 = sense_sync.port1_present && !sense_sync.port1_ovp
               && !sense_sync.bus_rail_present;
         ok2 = sense_sync.port2_present && !sense_sync.port2_ovp
               && !sense_sync.bus_rail_present;
         if (!ok1 || !pop_reg[0] || ctrl_next.high_impedance_enable)
            drive_next.port1_drive_state = 1'b0;
         if (!ok2 || !pop_reg[1] || ctrl_next.high_impedance_enable)
            drive_next.port2_drive_state = 1'b0;
         if (!wr_drive && (drive_next == '0)
             && !ctrl_next.high_impedance_enable) begin
            if (ok1 && pop_reg[0]) begin
               drive_next.port1_drive_state = 1'b1;
            end else if (ok2 && pop_reg[1]) begin
               drive_next.port2_drive_state = 1'b1;
            end
         end
      end
      if (ctrl_next.all_drivers_disable) begin
         drive_next = '0;
      end
   end

   // Control and drive state registers
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         ctrl_reg <= input_mux_pkg::ctrl_s'(`CTRL_RST);
         drive_reg <= input_mux_pkg::drive_s'(`DRIVE_RST);
      end else begin
         ctrl_reg <= ctrl_next;
         drive_reg <= drive_next;
      end
   end

   // ----------------------------------------
   // Gate and power stage outputs
   // ----------------------------------------
   // Drivers follow the next drive state, so outside reverse mode they and the state agree
   always_comb begin
      gate1_next = drive_next.port1_drive_state && pop_reg[0] && ok1
                   && !ctrl_next.all_drivers_disable
                   && !ctrl_next.high_impedance_enable;
      gate2_next = drive_next.port2_drive_state && pop_reg[1] && ok2
                   && !drive_next.port1_drive_state
                   && !ctrl_next.all_drivers_disable
                   && !ctrl_next.high_impedance_enable;
      bypass_next = ctrl_next.direct_path_enable
                    && ctrl_next.charge_enable
                    && !ctrl_next.high_impedance_enable;
      switch_next = !ctrl_next.direct_path_enable
                    && ctrl_next.charge_enable
                    && !ctrl_next.high_impedance_enable;
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         gate1_reg <= 1'b0;
         gate2_reg <= 1'b0;
         bypass_reg <= 1'b0;
         switch_reg <= 1'b0;
      end else begin
         gate1_reg <= gate1_next;
         gate2_reg <= gate2_next;
         bypass_reg <= bypass_next;
         switch_reg <= switch_next;
      end
   end

   // ----------------------------------------
   // Interrupts and read data
   // ----------------------------------------
   // A set in the same cycle as its clear wins, so no event is lost
   always_comb begin
      stat_next = stat_reg;
      en_next = en_reg;
      if (wr_clr)
         stat_next = stat_reg & ~input_mux_pkg::evt_s'(wdata[3:0]);
      stat_next = stat_next | evt;
      if (wr_en_reg)
         en_next = input_mux_pkg::evt_s'(wdata[3:0]);
      irq_next = |(stat_next & en_next);
      rdata_next = 8'h00;
      if (rd_en) begin
         case (addr)
            `OFS_CTRL: rdata_next = ctrl_reg;
            `OFS_DRIVE: rdata_next = {6'h00, drive_reg};
            `OFS_STATUS: rdata_next = {3'h0, gate2_reg, gate1_reg,
                                       &pop_reg, pop_reg};
            `OFS_IRQ_STAT: rdata_next = {4'h0, stat_reg};
            `OFS_IRQ_EN: rdata_next = {4'h0, en_reg};
            default: rdata_next = 8'h00; // Unmapped or write-only
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         stat_reg <= input_mux_pkg::evt_s'(`EVT_RST);
         en_reg <= input_mux_pkg::evt_s'(`EVT_RST);
         irq_reg <= 1'b0;
         rdata_reg <= 8'h00;
      end else begin
         stat_reg <= stat_next;
         en_reg <= en_next;
         irq_reg <= irq_next;
         rdata_reg <= rdata_next;
      end
   end

   assign rdata = rdata_reg;
   assign port1_gate_drive = gate1_reg;
   assign port2_gate_drive = gate2_reg;
   assign bypass_fets_on = bypass_reg;
   assign switcher_run = switch_reg;
   assign bus_pulldown_on = ctrl_reg.bus_pulldown_enable;
   assign port1_pulldown_on = ctrl_reg.port1_pulldown_enable;
   assign port2_pulldown_on = ctrl_reg.port2_pulldown_enable;
   assign irq = irq_reg;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   never_both_a: assert property (!(gate1_reg && gate2_reg))
      else $error("both gate drivers on");
   gate_cond_a: assert property ($rose(gate1_reg) |->
      $past(pop_reg[0]) && !ctrl_reg.all_drivers_disable
      && !ctrl_reg.high_impedance_enable)
      else $error("port 1 driver on without conditions");
   dis_clear_a: assert property (ctrl_reg.all_drivers_disable |->
      drive_reg == '0 && !gate1_reg && !gate2_reg)
      else $error("disable did not clear drive");
   hiz_off_a: assert property (ctrl_reg.high_impedance_enable |->
      !gate1_reg && !gate2_reg)
      else $error("driver on in high impedance");
   rev_entry_a: assert property (wr_ctrl && wdata[2]
      && !ctrl_reg.reverse_output_enable |=> ctrl_reg.all_drivers_disable)
      else $error("reverse entry left drivers enabled");
   wdog_rev_a: assert property (watchdog_expired |=>
      !ctrl_reg.reverse_output_enable)
      else $error("watchdog left reverse enabled");
   rev_fault_a: assert property (ctrl_reg.reverse_output_enable
      && rev_fault && !watchdog_expired && !wr_ctrl
      |=> drive_reg == '0 && ctrl_reg.reverse_output_enable)
      else $error("reverse fault handling wrong");
   direct_fault_a: assert property (any_fault && !wr_ctrl
      && ctrl_reg.direct_path_enable |=> !ctrl_reg.charge_enable
      && ctrl_reg.direct_path_enable ##1 !bypass_reg)
      else $error("direct fault did not stop charge");
   default_p1_a: assert property (!ctrl_next.reverse_output_enable
      && !wr_drive && drive_reg == '0 && gate1_next |=>
      gate1_reg && !gate2_reg && drive_reg.port1_drive_state)
      else $error("port 1 not chosen by default");
   dual_stat_a: assert property (rd_en && addr == `OFS_STATUS
      && pop_reg == 2'h3 |=> rdata_reg[2:0] == 3'h7)
      else $error("dual input not reported");
endmodule

// ===== core/input_mux_map.svh
// Register offsets, reset values and timing counts of the input selector.
// Assumes an 8-bit register port with byte offsets.
`ifndef INPUT_MUX_MAP_SVH
`define INPUT_MUX_MAP_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_DRIVE 8'h04
`define OFS_STATUS 8'h08
`define OFS_IRQ_STAT 8'h0C
`define OFS_IRQ_CLR 8'h10
`define OFS_IRQ_EN 8'h14
// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define CTRL_RST 8'h00
`define DRIVE_RST 2'h0
`define EVT_RST 4'h0
`define SENSE_RST 9'h000
`define POP_WAIT 2'h3
`endif

// ===== core/input_mux_pkg.sv
// Packed carriers used by the input selector only, not by its bench.
// Assumes the offsets in input_mux_map.svh.
package input_mux_pkg;
   // Control word, one byte, msb first
   typedef struct packed {
      logic port2_pulldown_enable; // Bit 7
      logic port1_pulldown_enable; // Bit 6
      logic bus_pulldown_enable; // Bit 5
      logic direct_path_enable; // Bit 4
      logic charge_enable; // Bit 3
      logic reverse_output_enable; // Bit 2
      logic high_impedance_enable; // Bit 1
      logic all_drivers_disable; // Bit 0
   } ctrl_s;
   // Per-port gate-drive state
   typedef struct packed {
      logic port2_drive_state; // Bit 1
      logic port1_drive_state; // Bit 0
   } drive_s;
   // Sticky events
   typedef struct packed {
      logic wdog_exit; // Bit 3
      logic charge_stop; // Bit 2
      logic drive_fault; // Bit 1
      logic reverse_entry; // Bit 0
   } evt_s;
   // Synchronised analog and strap inputs
   typedef struct packed {
      logic port2_fet_detect;
      logic port1_fet_detect;
      logic conv_fault;
      logic bus_overvoltage_fault;
      logic bus_rail_present;
      logic port2_ovp;
      logic port2_present;
      logic port1_ovp;
      logic port1_present;
   } sense_s;
endpackage

// ===== testbench/supply_model.sv
// Behavioural model of the two input ports, their FETs and the bus rail.
// Assumes the bench moves the levels right after a rising mclk edge.
`timescale 1ns/1ps
module supply_model #(
   parameter logic [7:0] PRESENT_LVL = 8'h20, // Input present level
   parameter logic [7:0] OVP_LVL = 8'hA0, // Port overvoltage level
   parameter logic [7:0] BUS_OVP_LVL = 8'hC0 // Bus overvoltage level
) (
   input wire logic [7:0] volt1, // Port 1 level
   input wire logic [7:0] volt2, // Port 2 level
   input wire logic [7:0] bus_v, // Bus rail level
   input wire logic fit1, // Port 1 FETs fitted strap level
   input wire logic fit2, // Port 2 FETs fitted strap level
   output logic port1_input, // Port 1 present
   output logic port1_ovp, // Port 1 overvoltage
   output logic port2_input, // Port 2 present
   output logic port2_ovp, // Port 2 overvoltage
   output logic bus_rail, // Bus present
   output logic bus_overvoltage_fault, // Bus overvoltage
   output logic port1_fet_detect, // Port 1 FETs fitted
   output logic port2_fet_detect // Port 2 FETs fitted
);
   // Straps follow the bench, which moves them only while in reset
   assign port1_fet_detect = fit1;
   assign port2_fet_detect = fit2;
   // Comparators follow the levels with no hysteresis
   assign port1_input = volt1 > PRESENT_LVL;
   assign port2_input = volt2 > PRESENT_LVL;
   // One overvoltage threshold for both ports
   assign port1_ovp = volt1 > OVP_LVL;
   assign port2_ovp = volt2 > OVP_LVL;
   assign bus_rail = bus_v > PRESENT_LVL;
   assign bus_overvoltage_fault = bus_v > BUS_OVP_LVL;
endmodule

// ===== testbench/input_mux_and_mode_control_test.sv
// Self-checking bench for the input selector and charging mode control.
// Assumes the register map of input_mux_map.svh and supply_model.
`timescale 1ns/1ps
`include "input_mux_map.svh"
module input_mux_and_mode_control_test;
   logic mclk = 1'b0, reset_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, volt1 = 8'h00;
   logic [7:0] volt2 = 8'h00, bus_v = 8'h00, d;
   logic watchdog_expired = 1'b0, conv_fault = 1'b0, fit2 = 1'b1;
   logic p1_in, p1_ovp, p2_in, p2_ovp, bus_ok, bus_ovp, det1, det2;
   logic g1, g2, byp, sw_run, bus_pd, pd1, pd2, irq;
   int num_errors = 0, n_checks = 0, cycles = 0;
   // ----------------------------------------
   // Clock, design and far side
   // ----------------------------------------
   initial forever #12.5 mclk = ~mclk;
   supply_model u_supply (.volt1(volt1), .volt2(volt2), .bus_v(bus_v),
      .fit1(1'b1), .fit2(fit2),
      .port1_input(p1_in), .port1_ovp(p1_ovp), .port2_input(p2_in),
      .port2_ovp(p2_ovp), .bus_rail(bus_ok),
      .bus_overvoltage_fault(bus_ovp), .port1_fet_detect(det1),
      .port2_fet_detect(det2));
   input_mux_ctrl u_dut (.mclk(mclk), .reset_n(reset_n), .addr(addr),
      .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
      .port1_input(p1_in), .port1_ovp(p1_ovp), .port2_input(p2_in),
      .port2_ovp(p2_ovp), .bus_rail(bus_ok),
      .bus_overvoltage_fault(bus_ovp), .conv_fault(conv_fault),
      .port1_fet_detect(det1), .port2_fet_detect(det2),
      .watchdog_expired(watchdog_expired), .port1_gate_drive(g1),
      .port2_gate_drive(g2), .bypass_fets_on(byp), .switcher_run(sw_run),
      .bus_pulldown_on(bus_pd), .port1_pulldown_on(pd1),
      .port2_pulldown_on(pd2), .irq(irq));
   // ----------------------------------------
   // Bus cycles and compares
   // ----------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge mclk) begin wr_en <= 1'b1; addr <= a; wdata <= v; end
      @(posedge mclk) wr_en <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge mclk) begin rd_en <= 1'b1; addr <= a; end
      @(posedge mclk) rd_en <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check1(input logic got, input logic exp);
      check8({7'h00, got}, {7'h00, exp});
   endtask
   task automatic reg_is(input logic [7:0] a, input logic [7:0] exp);
      rd(a);
      check8(d, exp);
   endtask
   // Async inputs need two sync flops and one register stage
   task automatic settle();
      repeat (6) @(posedge mclk);
      #1;
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Hang guard, far above the 150 or so cycles the run needs
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         give_verdict();
      end
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   // Forward selection: bus present blocks, port 1 primary, swap, hiz
   task automatic forward_mode();
      @(posedge mclk) begin volt1 <= 8'h50; volt2 <= 8'h50; end
      @(posedge mclk) bus_v <= 8'h50;
      settle();
      check1(g1 | g2, 1'b0);
      @(posedge mclk) bus_v <= 8'h00;
      settle();
      check1(g1, 1'b1);
      check1(g2, 1'b0);
      reg_is(`OFS_DRIVE, 8'h01);
      reg_is(`OFS_STATUS, 8'h0F);
      wr(`OFS_DRIVE, 8'h02);
      #1 check1(g1, 1'b0);
      check1(g2, 1'b1);
      wr(`OFS_CTRL, 8'h02);
      #1 check1(g1 | g2, 1'b0);
      wr(`OFS_CTRL, 8'h00);
      settle();
      check1(g1, 1'b1);
      wr(`OFS_CTRL, 8'h01);
      #1 check1(g1 | g2, 1'b0);
      reg_is(`OFS_DRIVE, 8'h00);
      wr(`OFS_CTRL, 8'h00);
      @(posedge mclk) volt1 <= 8'hB0;
      settle();
      check1(g2, 1'b1);
      check1(g1, 1'b0);
      @(posedge mclk) volt1 <= 8'h50;
      // Let the cleared overvoltage pass the syncs before reverse entry
      settle();
   endtask
   // Reverse entry with the interrupt, fault, rewrite and exit
   task automatic reverse_mode();
      wr(`OFS_CTRL, 8'h04);
      #1 check1(g1 | g2, 1'b0);
      reg_is(`OFS_CTRL, 8'h05);
      check1(irq, 1'b0);
      wr(`OFS_IRQ_EN, 8'h01);
      #1 check1(irq, 1'b1);
      reg_is(`OFS_IRQ_STAT, 8'h01);
      wr(`OFS_IRQ_CLR, 8'h01);
      #1 check1(irq, 1'b0);
      // host clears disable, then picks port 2
      wr(`OFS_CTRL, 8'h04);
      wr(`OFS_DRIVE, 8'h02);
      #1 check1(g2, 1'b1);
      @(posedge mclk) bus_v <= 8'hD0;
      settle();
      check1(g2, 1'b0);
      reg_is(`OFS_CTRL, 8'h04);
      reg_is(`OFS_IRQ_STAT, 8'h02);
      @(posedge mclk) bus_v <= 8'h00;
      settle();
      check1(g2, 1'b0);
      wr(`OFS_DRIVE, 8'h02);
      #1 check1(g2, 1'b1);
      // exit: pulldown, drop the port, leave reverse
      wr(`OFS_CTRL, 8'h24);
      #1 check1(bus_pd, 1'b1);
      wr(`OFS_DRIVE, 8'h00);
      #1 check1(g2, 1'b0);
      wr(`OFS_CTRL, 8'hC0);
      #1 check1(pd1 & pd2, 1'b1);
      wr(`OFS_CTRL, 8'h04);
      @(posedge mclk) watchdog_expired <= 1'b1;
      @(posedge mclk) watchdog_expired <= 1'b0;
      reg_is(`OFS_CTRL, 8'h01);
      wr(`OFS_CTRL, 8'h00);
   endtask
   // Direct path, fault in direct path, change back to switched mode
   task automatic direct_mode();
      wr(`OFS_CTRL, 8'h18);
      #1 check1(byp, 1'b1);
      check1(sw_run, 1'b0);
      @(posedge mclk) conv_fault <= 1'b1;
      settle();
      reg_is(`OFS_CTRL, 8'h10);
      check1(byp, 1'b0);
      @(posedge mclk) conv_fault <= 1'b0;
      // charge off, mode bit, charge on
      wr(`OFS_CTRL, 8'h00);
      wr(`OFS_CTRL, 8'h08);
      #1 check1(sw_run, 1'b1);
      check1(byp, 1'b0);
      reg_is(8'h3C, 8'h00);
   endtask
   // Port 2 strap absent through a mid-run reset: single pair only
   task automatic single_pair();
      @(posedge mclk) begin
         reset_n <= 1'b0;
         fit2 <= 1'b0;
         volt1 <= 8'hB0;
      end
      repeat (3) @(posedge mclk);
      reset_n <= 1'b1;
      settle();
      // Port 2 is present and clean, only its missing pair blocks it
      check1(g1 | g2, 1'b0);
      reg_is(`OFS_STATUS, 8'h01);
      @(posedge mclk) volt1 <= 8'h50;
      settle();
      check1(g1, 1'b1);
      check1(g2, 1'b0);
      reg_is(`OFS_STATUS, 8'h09);
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (3) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      #1 check1(g1 | g2 | irq, 1'b0);
      reg_is(`OFS_CTRL, `CTRL_RST);
      repeat (8) @(posedge mclk);
      forward_mode();
      reverse_mode();
      direct_mode();
      single_pair();
      give_verdict();
   end
endmodule
